//--- rtl/i2ctr_target.sv
// Purpose: I2C target that writes and reads 16-bit registers by byte pairs
// Assumes: reg_rd_data follows reg_rd_addr combinationally or within a few cycles
// Notes:   Target only; SCL is never driven, SDA is open drain
// Behaviour
// [RQ1] Target only, SCL up to 400 kHz
// [RQ2] Address in bits 7..1, bit 0 direction
// [RQ3] Select pins set address bits 1, 2
// [RQ4] Also answer broadcast address 0001110
// [RQ5] Registers move as two-byte pairs
// [RQ6] MSB first, high byte before low
// [RQ7] Acknowledge write address and pointer byte
// [RQ8] Acknowledge high and low data bytes
// [RQ9] Pointer advances after each written pair
// [RQ10] Read starts with pointer write, repeated START
// [RQ11] Ack read address, send high then low
// [RQ12] Host ack on low byte: next register
// [RQ13] Host nack: release SDA, await STOP
// [RQ14] Write only on complete pair; drop partial
// [RQ15] No acknowledge for unmatched address
`timescale 1ns/1ps
`default_nettype none
module i2ctr_target #(
  parameter int CLK_PERIOD_NS = 8  // System clock period
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        addr_select_pin_low,
  input  wire logic        addr_select_pin_high,
  output logic [7:0]       reg_rd_addr,
  input  wire logic [15:0] reg_rd_data,
  output logic             reg_wr,
  output logic [7:0]       reg_wr_addr,
  output logic [15:0]      reg_wr_data
);
  // Shortest SCL high phase in system cycles, rounded up
  localparam int HIGH_CYCLES = (i2ctr_pkg::T_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Too slow a clock would miss SCL phases at 400 kHz
  if (HIGH_CYCLES < i2ctr_pkg::MIN_SAMPLES) begin : g_clk_check  // [RQ1]
    $error("system clock too slow for the fastest SCL rate");
  end

  i2ctr_if bus ();
  i2ctr_pkg::i2ctr_state_t state;   // Bus phase
  i2ctr_pkg::i2ctr_kind_t  kind;    // Meaning of the current received byte
  logic [3:0]  bitcnt;              // Bits shifted in or out
  logic        rw;                  // Direction from the address byte
  logic [7:0]  rx_sh;               // Receive shifter
  logic [7:0]  tx_sh;               // Transmit shifter, MSB at top
  logic        tx_low;              // Low byte of the pair is on the bus
  logic [15:0] rd_word;             // Word captured when its high byte starts
  logic [7:0]  ptr;                 // Register pointer
  logic [7:0]  msb_hold;            // High byte waiting for its partner
  logic        host_ack;            // Host answer sampled on the ninth clock
  logic [6:0]  dev_addr;            // Pin-selected address
  logic        addr_hit;            // Address byte is ours
  logic        bus_ev;              // START or STOP this cycle
  logic        byte_done;           // Eighth-clock falling edge ending a received byte
  logic        rd_next;             // Host acked the low byte
  logic [7:0]  load_byte;           // Next byte to transmit
  i2ctr_pkg::i2ctr_kind_t next_kind;

  i2ctr_sync u_sync (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .ads_low_i  (addr_select_pin_low),
    .ads_high_i (addr_select_pin_high),
    .bus        (bus)
  );

  // ==========================================================
  // Decode helpers
  assign dev_addr  = {i2ctr_pkg::DEV_ADDR_UPPER, bus.ads_high, bus.ads_low};  // [RQ3]
  assign addr_hit  = (rx_sh[7:1] == dev_addr) || (rx_sh[7:1] == i2ctr_pkg::GEN_ADDR);  // [RQ2] [RQ4]
  assign bus_ev    = bus.start | bus.stop;
  assign byte_done = (state == i2ctr_pkg::ST_RX) && bus.scl_fall && (bitcnt == i2ctr_pkg::BYTE_END) && !bus_ev;
  assign rd_next   = (state == i2ctr_pkg::ST_HACK) && bus.scl_rise && tx_low && !bus.sda && !bus_ev;
  // Low byte from the captured word, otherwise a fresh high byte
  assign load_byte = ((state == i2ctr_pkg::ST_HACK) && !tx_low) ? rd_word[7:0] : reg_rd_data[15:8];  // [RQ6]
  assign sda_o       = 1'h0;  // Open drain: only ever pulls low
  assign reg_rd_addr = ptr;

  // Byte sequence of a write: address, pointer, then pairs
  always_comb begin
    case (kind)
      i2ctr_pkg::K_ADDR: next_kind = i2ctr_pkg::K_PTR;
      i2ctr_pkg::K_PTR:  next_kind = i2ctr_pkg::K_MSB;
      i2ctr_pkg::K_MSB:  next_kind = i2ctr_pkg::K_LSB;
      default:           next_kind = i2ctr_pkg::K_MSB;  // [RQ9]
    endcase
  end

  // ==========================================================
  // Phase machine; START wins over everything except reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state  <= i2ctr_pkg::ST_IDLE;
      kind   <= i2ctr_pkg::K_ADDR;
      bitcnt <= i2ctr_pkg::BIT_ZERO;
      rw     <= 1'h0;
    end else if (bus.start) begin
      // Repeated START restarts at the address byte
      state  <= i2ctr_pkg::ST_RX;  // [RQ10]
      kind   <= i2ctr_pkg::K_ADDR;
      bitcnt <= i2ctr_pkg::BIT_ZERO;
    end else if (bus.stop) begin
      state <= i2ctr_pkg::ST_IDLE;
    end else begin
      case (state)
        i2ctr_pkg::ST_RX: begin
          if (bus.scl_rise) begin
            bitcnt <= 4'(bitcnt + i2ctr_pkg::BIT_STEP);
          end else if (byte_done) begin
            if (kind == i2ctr_pkg::K_ADDR && !addr_hit) begin
              state <= i2ctr_pkg::ST_IDLE;  // [RQ15]
            end else begin
              state <= i2ctr_pkg::ST_ACK;
            end
            if (kind == i2ctr_pkg::K_ADDR) begin
              rw <= (rx_sh[0] == i2ctr_pkg::RW_READ);  // [RQ2]
            end
          end
        end
        i2ctr_pkg::ST_ACK: begin
          if (bus.scl_fall) begin
            if (kind == i2ctr_pkg::K_ADDR && rw) begin
              state  <= i2ctr_pkg::ST_TX;  // [RQ11]
              bitcnt <= i2ctr_pkg::BIT_FIRST;
            end else begin
              state  <= i2ctr_pkg::ST_RX;
              kind   <= next_kind;
              bitcnt <= i2ctr_pkg::BIT_ZERO;
            end
          end
        end
        i2ctr_pkg::ST_TX: begin
          if (bus.scl_fall) begin
            if (bitcnt == i2ctr_pkg::BYTE_END) begin
              state <= i2ctr_pkg::ST_HACK;
            end else begin
              bitcnt <= 4'(bitcnt + i2ctr_pkg::BIT_STEP);
            end
          end
        end
        i2ctr_pkg::ST_HACK: begin
          if (bus.scl_fall) begin
            if (host_ack) begin
              state  <= i2ctr_pkg::ST_TX;  // [RQ12]
              bitcnt <= i2ctr_pkg::BIT_FIRST;
            end else begin
              state <= i2ctr_pkg::ST_IDLE;  // [RQ13]
            end
          end
        end
        default: state <= i2ctr_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Receive shifter, MSB first
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_sh <= 8'h00;
    end else if (state == i2ctr_pkg::ST_RX && bus.scl_rise && !bus_ev) begin
      rx_sh <= {rx_sh[6:0], bus.sda};  // [RQ6]
    end
  end

  // ==========================================================
  // Host acknowledge sample on the ninth clock
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      host_ack <= 1'h0;
    end else if (state == i2ctr_pkg::ST_HACK && bus.scl_rise) begin
      host_ack <= !bus.sda;
    end
  end

  // ==========================================================
  // SDA drive: acknowledges and read data, changed only after SCL falls
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sda_oe  <= 1'h0;
      tx_sh   <= 8'h00;
      tx_low  <= 1'h0;
      rd_word <= i2ctr_pkg::WORD_RESET;
    end else if (bus_ev) begin
      sda_oe <= 1'h0;
    end else begin
      case (state)
        i2ctr_pkg::ST_RX: begin
          if (byte_done && !(kind == i2ctr_pkg::K_ADDR && !addr_hit)) begin
            sda_oe <= 1'h1;  // [RQ7] [RQ8]
          end
        end
        i2ctr_pkg::ST_ACK, i2ctr_pkg::ST_HACK: begin
          if (bus.scl_fall && (state == i2ctr_pkg::ST_HACK ? host_ack : (kind == i2ctr_pkg::K_ADDR && rw))) begin
            // First bit of the next byte goes out with this edge
            sda_oe <= !load_byte[7];  // [RQ11]
            tx_sh  <= {load_byte[6:0], 1'h0};
            if (state == i2ctr_pkg::ST_HACK && !tx_low) begin
              tx_low <= 1'h1;  // [RQ5]
            end else begin
              tx_low  <= 1'h0;
              rd_word <= reg_rd_data;
            end
          end else if (bus.scl_fall) begin
            sda_oe <= 1'h0;  // [RQ13]
          end
        end
        i2ctr_pkg::ST_TX: begin
          if (bus.scl_fall) begin
            if (bitcnt == i2ctr_pkg::BYTE_END) begin
              sda_oe <= 1'h0;
            end else begin
              sda_oe <= !tx_sh[7];  // [RQ6]
              tx_sh  <= {tx_sh[6:0], 1'h0};
            end
          end
        end
        default: sda_oe <= 1'h0;
      endcase
    end
  end

  // ==========================================================
  // Pointer and write port; only a complete pair reaches a register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ptr         <= i2ctr_pkg::PTR_RESET;
      msb_hold    <= 8'h00;
      reg_wr      <= 1'h0;
      reg_wr_addr <= i2ctr_pkg::PTR_RESET;
      reg_wr_data <= i2ctr_pkg::WORD_RESET;
    end else begin
      reg_wr <= 1'h0;
      if (byte_done) begin
        if (kind == i2ctr_pkg::K_PTR) begin
          ptr <= rx_sh;
        end else if (kind == i2ctr_pkg::K_MSB) begin
          msb_hold <= rx_sh;
        end else if (kind == i2ctr_pkg::K_LSB) begin
          reg_wr      <= 1'h1;  // [RQ14]
          reg_wr_addr <= ptr;
          reg_wr_data <= {msb_hold, rx_sh};  // [RQ5]
          ptr         <= 8'(ptr + i2ctr_pkg::PTR_STEP);  // [RQ9]
        end
      end else if (rd_next) begin
        // Advance early so the next word settles before SCL falls
        ptr <= 8'(ptr + i2ctr_pkg::PTR_STEP);  // [RQ12]
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_ack_on_match: assert property (  // [RQ3]
    (state == i2ctr_pkg::ST_RX && kind == i2ctr_pkg::K_ADDR && byte_done && addr_hit)
      |=> sda_oe && state == i2ctr_pkg::ST_ACK)
    else $error("matched address not acknowledged");
  chk_no_ack_miss: assert property (  // [RQ15]
    (state == i2ctr_pkg::ST_RX && kind == i2ctr_pkg::K_ADDR && byte_done && !addr_hit)
      |=> !sda_oe && state == i2ctr_pkg::ST_IDLE)
    else $error("unmatched address was acknowledged");
  chk_wr_full_pair: assert property (  // [RQ14]
    reg_wr |-> $past(kind) == i2ctr_pkg::K_LSB && $past(state) == i2ctr_pkg::ST_RX)
    else $error("write strobe without a complete pair");
  chk_ptr_after_wr: assert property (  // [RQ9]
    reg_wr |-> ptr == 8'(reg_wr_addr + i2ctr_pkg::PTR_STEP))
    else $error("pointer did not advance after write");
  chk_nack_release: assert property (  // [RQ13]
    (state == i2ctr_pkg::ST_HACK && bus.scl_fall && !host_ack && !bus_ev)
      |=> !sda_oe && state == i2ctr_pkg::ST_IDLE)
    else $error("SDA held after host nack");
  chk_rx_sda_free: assert property (  // [RQ7]
    (state == i2ctr_pkg::ST_RX && $past(state) == i2ctr_pkg::ST_RX) |-> !sda_oe)
    else $error("SDA driven while host sends a byte");
  chk_msb_first: assert property (  // [RQ11]
    (state == i2ctr_pkg::ST_ACK && bus.scl_fall && kind == i2ctr_pkg::K_ADDR && rw && !bus_ev)
      |=> state == i2ctr_pkg::ST_TX && sda_oe == !$past(reg_rd_data[15]))
    else $error("read did not start with high byte MSB");
  chk_rd_ptr_adv: assert property (  // [RQ12]
    rd_next |=> ptr == 8'($past(ptr) + i2ctr_pkg::PTR_STEP))
    else $error("pointer did not advance on host ack");
  chk_start_restart: assert property (  // [RQ10]
    bus.start |=> state == i2ctr_pkg::ST_RX && kind == i2ctr_pkg::K_ADDR && !sda_oe)
    else $error("START did not restart address phase");
endmodule
`default_nettype wire

//--- rtl/i2ctr_pkg.sv
// Purpose: Shared constants and types for the I2C target register access block
// Assumes: 125 MHz system clock, open-drain SDA, SCL from the bus controller
// Notes:   Device addresses are 7-bit, register addresses 8-bit, shifted MSB first
`default_nettype none
package i2ctr_pkg;
  // ==========================================================
  // Addressing
  localparam logic [4:0] DEV_ADDR_UPPER = 5'h0d;  // Fixed upper bits 01101
  localparam logic [6:0] GEN_ADDR       = 7'h0e;  // Broadcast address 0001110
  localparam logic       RW_READ        = 1'h1;   // Direction bit for read
  // ==========================================================
  // Byte framing and reset values
  localparam logic [3:0]  BYTE_END   = 4'h8;      // Bits per byte
  localparam logic [3:0]  BIT_FIRST  = 4'h1;      // First bit already driven
  localparam logic [3:0]  BIT_ZERO   = 4'h0;      // Counter restart
  localparam logic [3:0]  BIT_STEP   = 4'h1;      // Counter step
  localparam logic [7:0]  PTR_RESET  = 8'h00;     // Pointer after reset
  localparam logic [7:0]  PTR_STEP   = 8'h01;     // Auto-increment step
  localparam logic [15:0] WORD_RESET = 16'h0000;  // Data holding reset
  localparam logic [3:0]  SYNC_RESET = 4'h3;      // Idle bus: SDA and SCL high
  // ==========================================================
  // Bus timing
  localparam int SCL_MAX_KHZ   = 400;             // Fastest supported SCL
  localparam int T_HIGH_MIN_NS = 600;             // Shortest SCL high phase
  localparam int MIN_SAMPLES   = 4;               // Samples needed per phase
  // ==========================================================
  // State machine and byte kinds
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX   = 3'b001,
    ST_ACK  = 3'b010,
    ST_TX   = 3'b011,
    ST_HACK = 3'b100
  } i2ctr_state_t;
  typedef enum logic [1:0] {
    K_ADDR = 2'b00,
    K_PTR  = 2'b01,
    K_MSB  = 2'b10,
    K_LSB  = 2'b11
  } i2ctr_kind_t;
endpackage
`default_nettype wire

//--- rtl/i2ctr_if.sv
// Purpose: Bus events passed from the pin front end to the target logic
// Assumes: All signals are on sys_clk
// Notes:   Edges and conditions are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface i2ctr_if;
  logic scl_rise;   // SCL low to high
  logic scl_fall;   // SCL high to low
  logic start;      // START or repeated START
  logic stop;       // STOP
  logic sda;        // Synchronised SDA level
  logic ads_low;    // Synchronised select pin for address bit 1
  logic ads_high;   // Synchronised select pin for address bit 2
  modport src (output scl_rise, scl_fall, start, stop, sda, ads_low, ads_high);
  modport dst (input  scl_rise, scl_fall, start, stop, sda, ads_low, ads_high);
endinterface
`default_nettype wire

//--- rtl/i2ctr_sync.sv
// Purpose: Synchronise bus pins and detect SCL edges, START and STOP
// Assumes: Pins are asynchronous to sys_clk
// Notes:   No spike filter; the oversampling margin absorbs short glitches
`timescale 1ns/1ps
`default_nettype none
module i2ctr_sync (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic ads_low_i,
  input  wire logic ads_high_i,
  i2ctr_if.src      bus
);
  logic [3:0] stage1;  // First flops, read only by stage2
  logic [3:0] stage2;  // Settled levels
  logic [1:0] dly;     // Previous SDA and SCL for edge finding

  // ==========================================================
  // Two-flop synchroniser plus one delay stage
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stage1 <= i2ctr_pkg::SYNC_RESET;
      stage2 <= i2ctr_pkg::SYNC_RESET;
      dly    <= i2ctr_pkg::SYNC_RESET[1:0];
    end else begin
      stage1 <= {ads_high_i, ads_low_i, sda_i, scl_i};
      stage2 <= stage1;
      dly    <= stage2[1:0];
    end
  end

  // ==========================================================
  // Event decode; START and STOP need SCL high on both samples
  assign bus.scl_rise = stage2[0] & ~dly[0];
  assign bus.scl_fall = ~stage2[0] & dly[0];
  assign bus.start    = stage2[0] & dly[0] & dly[1] & ~stage2[1];  // [RQ2]
  assign bus.stop     = stage2[0] & dly[0] & ~dly[1] & stage2[1];
  assign bus.sda      = stage2[1];
  assign bus.ads_low  = stage2[2];
  assign bus.ads_high = stage2[3];

  chk_start_scl_high: assert property (@(posedge sys_clk) disable iff (!rst_n)  // [RQ2]
    bus.start |-> !bus.stop && !bus.scl_rise && !bus.scl_fall)
    else $error("start coincides with another bus event");
endmodule
`default_nettype wire

//--- verif/i2ctr_host.sv
// Purpose: Bus controller model that frames START, STOP and bytes on SCL/SDA
// Assumes: SDA wire is resolved in the bench with a pull-up
// Notes:   SCL stands high outside frames; one bit lasts 125 ns
`timescale 1ns/1ps
`default_nettype none
module i2ctr_host (
  output logic     scl,
  output logic     sda_pull,
  input  wire logic sda
);
  localparam real Q = 31.25;  // Quarter of an SCL period

  // ==========================================================
  // Idle bus: both lines released
  initial begin
    scl = 1'h1;
    sda_pull = 1'h0;
  end

  // One bit: data set a quarter after SCL fall, sampled mid-high
  task automatic bit_xfer(input logic d, output logic s);
    sda_pull = ~d;
    #Q;
    scl = 1'h1;
    #Q;
    s = sda;
    #Q;
    scl = 1'h0;
    #Q;
  endtask

  // START or repeated START: SDA falls while SCL is high
  task automatic start();
    sda_pull = 1'h0;
    #Q;
    scl = 1'h1;
    #Q;
    sda_pull = 1'h1;
    #Q;
    scl = 1'h0;
    #Q;
  endtask

  // STOP, then bus free time before the next frame
  task automatic stop();
    sda_pull = 1'h1;
    #Q;
    scl = 1'h1;
    #Q;
    sda_pull = 1'h0;
    #(4 * Q);
  endtask

  // Controller to device byte, MSB first, returns the device ack
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(b[i], s);
    end
    bit_xfer(1'h1, s);
    ack = ~s;
  endtask

  // Device to controller byte; ack low drives a not-acknowledge
  task automatic rbyte(output logic [7:0] b, input logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'h1, s);
      b[i] = s;
    end
    bit_xfer(~ack, s);
  endtask
endmodule
`default_nettype wire

//--- verif/tb.sv
// Purpose: Self-checking bench for the I2C target register access block
// Assumes: Register file lives in the bench behind the read and write ports
// Notes:   A reference array tracks every expected register word
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int LIMIT = 60000;  // Ceiling on clock cycles
  logic        sys_clk;
  logic        rst_n;
  logic        pin_low;
  logic        pin_high;
  logic        scl;
  logic        sda_pull;
  logic        sda_line;
  logic        sda_o;
  logic        sda_oe;
  logic [7:0]  reg_rd_addr;
  logic [15:0] reg_rd_data;
  logic        reg_wr;
  logic [7:0]  reg_wr_addr;
  logic [15:0] reg_wr_data;
  logic [15:0] mem [256];    // Register file seen by the design
  logic [15:0] model [256];  // Expected register contents
  logic [23:0] got_q [$];    // Observed writes {addr,data}
  logic [23:0] exp_q [$];    // Expected writes
  logic [31:0] seed = 32'h26;
  int          n_errors = 0;
  int          checks = 0;
  int          cyc = 0;

  // ==========================================================
  // Clock, wire resolution and register file
  initial sys_clk = 1'h0;
  always #4 sys_clk = ~sys_clk;
  assign sda_line = ~(sda_pull | (sda_oe & ~sda_o));  // Pull-up on SDA; device pulls only with data low
  assign reg_rd_data = mem[reg_rd_addr];
  always @(posedge sys_clk) begin
    if (reg_wr === 1'h1) begin
      mem[reg_wr_addr] <= reg_wr_data;
      got_q.push_back({reg_wr_addr, reg_wr_data});
    end
  end

  i2ctr_target i_i2ctr_target (
    .sys_clk              (sys_clk),
    .rst_n                (rst_n),
    .scl_i                (scl),
    .sda_i                (sda_line),
    .sda_o                (sda_o),
    .sda_oe               (sda_oe),
    .addr_select_pin_low  (pin_low),
    .addr_select_pin_high (pin_high),
    .reg_rd_addr          (reg_rd_addr),
    .reg_rd_data          (reg_rd_data),
    .reg_wr               (reg_wr),
    .reg_wr_addr          (reg_wr_addr),
    .reg_wr_data          (reg_wr_data)
  );
  i2ctr_host i_i2ctr_host (
    .scl      (scl),
    .sda_pull (sda_pull),
    .sda      (sda_line)
  );

  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [6:0] own(input logic [1:0] p);
    return {5'h0d, p};  // Pin high is bit 2, pin low bit 1
  endfunction

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Pins change just after a clock edge, then settle through the sync
  task automatic set_pins(input logic [1:0] p);
    @(posedge sys_clk);
    #1;
    {pin_high, pin_low} = p;
    repeat (8) @(posedge sys_clk);
  endtask

  // Address and pointer phase shared by writes and reads
  task automatic head(input logic [6:0] a, input logic [7:0] ptr);
    logic ack;
    i_i2ctr_host.start();
    i_i2ctr_host.wbyte({a, 1'h0}, ack);
    chk(24'(ack), 24'h1);
    i_i2ctr_host.wbyte(ptr, ack);
    chk(24'(ack), 24'h1);
  endtask

  // Write n pairs; cut 1 adds a lone high byte ended by STOP, cut 2 by repeated START
  task automatic wr_burst(input logic [6:0] a, input logic [7:0] ptr, input int n, input int cut);
    logic ack;
    logic [15:0] w;
    head(a, ptr);
    for (int i = 0; i < n; i++) begin
      w = rnd();
      i_i2ctr_host.wbyte(w[15:8], ack);
      chk(24'(ack), 24'h1);
      i_i2ctr_host.wbyte(w[7:0], ack);
      chk(24'(ack), 24'h1);
      exp_q.push_back({ptr, w});
      model[ptr] = w;
      ptr++;
    end
    if (cut != 0) begin
      i_i2ctr_host.wbyte(8'h5a, ack);
      chk(24'(ack), 24'h1);
      if (cut == 2) begin
        i_i2ctr_host.start();
      end
    end
    i_i2ctr_host.stop();
    chk(24'(got_q.size()), 24'(exp_q.size()));
    while (got_q.size() > 0 && exp_q.size() > 0) begin
      chk(got_q.pop_front(), exp_q.pop_front());
    end
    got_q.delete();
    exp_q.delete();
  endtask

  // Pointer write, repeated START, n words read, last one refused
  task automatic rd_burst(input logic [6:0] a, input logic [7:0] ptr, input int n);
    logic ack;
    logic [7:0] hi;
    logic [7:0] lo;
    head(a, ptr);
    i_i2ctr_host.start();
    i_i2ctr_host.wbyte({a, 1'h1}, ack);
    chk(24'(ack), 24'h1);
    for (int i = 0; i < n; i++) begin
      i_i2ctr_host.rbyte(hi, 1'h1);
      i_i2ctr_host.rbyte(lo, i < n - 1);
      chk({8'h00, hi, lo}, {8'h00, model[ptr]});
      ptr++;
    end
    chk(24'(sda_oe), 24'h0);
    i_i2ctr_host.stop();
  endtask

  // ==========================================================
  // Cycle ceiling cuts a hang short
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_errors++;
      $display("timeout at cycle %0d", cyc);
      print_verdict();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic ack;
    logic [6:0] cand [4];
    rst_n = 1'h0;
    pin_low = 1'h0;
    pin_high = 1'h0;
    for (int i = 0; i < 256; i++) begin
      mem[i] = rnd();
      model[i] = mem[i];
    end
    repeat (20) @(posedge sys_clk);
    #1;
    chk({sda_o, sda_oe, reg_wr, reg_rd_addr}, 24'h0);  // Outputs idle in reset
    chk({reg_wr_addr, reg_wr_data}, 24'h0);             // Write port cleared in reset
    rst_n = 1'h1;
    repeat (8) @(posedge sys_clk);
    $display("test reset done");
    // Own, neighbour, broadcast and foreign address per pin setting
    for (int p = 0; p < 4; p++) begin
      set_pins(2'(p));
      cand = '{own(2'(p)), own(2'(p + 1)), 7'h0e, 7'h50};
      for (int k = 0; k < 4; k++) begin
        i_i2ctr_host.start();
        i_i2ctr_host.wbyte({cand[k], 1'h0}, ack);
        chk(24'(ack), 24'((k == 0) || (k == 2)));
        i_i2ctr_host.stop();
      end
    end
    $display("test address decode done");
    set_pins(2'h2);
    wr_burst(own(2'h2), 8'h10, 3, 1'b0);
    wr_burst(7'h0e, 8'hff, 2, 1'b0);
    wr_burst(own(2'h2), 8'h20, 1, 1'b1);
    $display("test writes done");
    rd_burst(own(2'h2), 8'h10, 3);
    rd_burst(7'h0e, 8'hff, 2);
    $display("test reads done");
    for (int k = 0; k < 4; k++) begin
      set_pins(2'(k));
      wr_burst(own(2'(k)), 8'(rnd()), 1 + (rnd() % 3), k % 3);
      rd_burst(own(2'(k)), 8'(rnd()), 2);
    end
    $display("test random done");
    print_verdict();
  end
endmodule
`default_nettype wire
